// ===== design/opaddr_pkg.sv
`default_nettype none
package opaddr_pkg;
   localparam logic [15:0] SHORT_BASE_LO = 16'hFE00;
   localparam logic [7:0] SHORT_WRAP_LIMIT = 8'h20;
   localparam logic [15:0] SHORT_RAM_FIRST = 16'hFE20;
   localparam logic [15:0] SHORT_RAM_LAST = 16'hFEFF;
   localparam logic [15:0] SHORT_SFR_FIRST = 16'hFF00;
   localparam logic [15:0] SHORT_SFR_LAST = 16'hFF1F;
   localparam logic [7:0] SFR_HIGH_BYTE = 8'hFF;
   localparam logic [7:0] SFR_GAP_FIRST = 8'hD0;
   localparam logic [7:0] SFR_GAP_LAST = 8'hDF;
   localparam int SHORT_BIT8_POS = 8;

   // operand addressing modes
   typedef enum logic [3:0] {
      MODE_NONE = 4'h0,
      MODE_DIRECT = 4'h1,
      MODE_SHORT = 4'h2,
      MODE_SFR = 4'h3,
      MODE_REG = 4'h4,
      MODE_REG_PAIR = 4'h5,
      MODE_INDIRECT = 4'h6,
      MODE_BASED = 4'h7,
      MODE_STACK = 4'h8,
      MODE_JUMP_REG = 4'h9,
      MODE_REL_BRANCH = 4'hA
   } mode_t;

   // target of the effective address
   typedef enum logic [1:0] {
      AREA_MEMORY = 2'h0,
      AREA_HS_RAM = 2'h1,
      AREA_SFR = 2'h2,
      AREA_REGFILE = 2'h3
   } area_t;

   typedef struct packed {
      mode_t mode;
      logic [15:0] absolute_address_operand;
      logic [7:0] field8;
      logic [2:0] reg_code;
      logic [1:0] pair_operand;
      logic indirect_sel_base;
      logic [2:0] bit_pos;
      logic [7:0] branch_displacement;
      logic [15:0] next_pc;
   } decode_t;

   typedef struct packed {
      logic [15:0] accumulator_pair;
      logic [15:0] pair1;
      logic [15:0] pointer_pair;
      logic [15:0] base_pair;
      logic [15:0] stack_ptr;
   } regs_t;

   typedef struct packed {
      logic valid;
      logic [15:0] ea;
      area_t area;
      logic [2:0] reg_sel;
      logic [1:0] pair_sel;
      logic [7:0] bit_mask;
      logic pc_load;
      logic sfr_hole;
   } result_t;
endpackage : opaddr_pkg
`default_nettype wire

// ===== design/operand_address_generator.sv
`default_nettype none
module operand_address_generator
   import opaddr_pkg::*;
(
   // clock and reset
   input wire logic I_REF_CLK,
   input wire logic I_RST,
   // decoded instruction and register contents
   input wire logic I_VALID,
   input wire decode_t I_DEC,
   input wire regs_t I_REGS,
   // effective address result
   output var result_t O_RES
);
   result_t res_reg;
   result_t res_next;

   // candidate addresses, one per addressing form except the register modes
   logic [15:0] direct_addr;
   logic [15:0] short_addr;
   logic [15:0] sfr_addr;
   logic [15:0] indirect_addr;
   logic [15:0] based_addr;
   logic [15:0] stack_addr;
   logic [15:0] jump_addr;
   logic [15:0] branch_addr;

   // extended operands and bit decode
   logic [15:0] offset_ext;
   logic [15:0] disp_ext;
   logic sfr_in_gap;
   logic [7:0] one_hot_bit;

   // inclusive range test
   function automatic logic in_range(
      input logic [15:0] a,
      input logic [15:0] lo,
      input logic [15:0] hi
   );
      return (a >= lo) && (a <= hi);
   endfunction : in_range

   // offset taken as a positive number
   function automatic logic [15:0] zero_ext8(input logic [7:0] b);
      return {8'h00, b};
   endfunction : zero_ext8

   // two's complement displacement
   function automatic logic [15:0] sign_ext8(input logic [7:0] b);
      return {{8{b[7]}}, b};
   endfunction : sign_ext8

   // one bit of a byte
   function automatic logic [7:0] bit_onehot(input logic [2:0] pos);
      logic [7:0] mask;
      mask = 8'h00;
      mask[pos] = 1'b1;
      return mask;
   endfunction : bit_onehot

   function automatic logic [15:0] short_ea(input logic [7:0] f);
      logic [15:0] ea;
      ea = SHORT_BASE_LO;
      ea[SHORT_BIT8_POS] = (f < SHORT_WRAP_LIMIT);
      ea[7:0] = f;
      return ea;
   endfunction : short_ea

   function automatic area_t area_of(input logic [15:0] a);
      area_t area;
      if (a >= SHORT_SFR_FIRST)
      begin
         area = AREA_SFR;
      end
      else if (in_range(a, SHORT_RAM_FIRST, SHORT_RAM_LAST))
      begin
         area = AREA_HS_RAM;
      end
      else
      begin
         area = AREA_MEMORY;
      end
      return area;
   endfunction : area_of

   // operand preparation shared by the mode decode
   always_comb
   begin
      offset_ext = zero_ext8(I_DEC.field8);
      disp_ext = sign_ext8(I_DEC.branch_displacement);
      direct_addr = I_DEC.absolute_address_operand;
      short_addr = short_ea(I_DEC.field8);
      sfr_addr = {SFR_HIGH_BYTE, I_DEC.field8};
      if (I_DEC.indirect_sel_base)
      begin
         indirect_addr = I_REGS.base_pair;
      end
      else
      begin
         indirect_addr = I_REGS.pointer_pair;
      end

      // carry out of bit 15 is dropped on purpose
      based_addr = 16'(I_REGS.base_pair + offset_ext);
      stack_addr = I_REGS.stack_ptr;
      jump_addr = I_REGS.accumulator_pair;
      branch_addr = 16'(I_DEC.next_pc + disp_ext);

      // D0H-DFH still yields an SFR address in this mode, flagged through sfr_hole
      sfr_in_gap = in_range(sfr_addr, {SFR_HIGH_BYTE, SFR_GAP_FIRST}, {SFR_HIGH_BYTE, SFR_GAP_LAST});
      one_hot_bit = bit_onehot(I_DEC.bit_pos);
   end

   // mode decode selects one candidate
   always_comb
   begin
      res_next = '0;
      res_next.valid = I_VALID;
      res_next.area = AREA_MEMORY;
      res_next.bit_mask = one_hot_bit;
      unique case (I_DEC.mode)
         MODE_DIRECT:
         begin
            res_next.ea = direct_addr;
            res_next.area = area_of(direct_addr);
         end

         MODE_SHORT:
         begin
            res_next.ea = short_addr;
            res_next.area = area_of(short_addr);
         end

         MODE_SFR:
         begin
            res_next.ea = sfr_addr;
            res_next.area = AREA_SFR;
            res_next.sfr_hole = sfr_in_gap;
         end

         MODE_REG:
         begin
            res_next.area = AREA_REGFILE;
            res_next.reg_sel = I_DEC.reg_code;
         end

         MODE_REG_PAIR:
         begin
            res_next.area = AREA_REGFILE;
            res_next.pair_sel = I_DEC.pair_operand;
         end

         MODE_INDIRECT:
         begin
            res_next.ea = indirect_addr;
            res_next.area = area_of(indirect_addr);
         end

         MODE_BASED:
         begin
            res_next.ea = based_addr;
            res_next.area = area_of(based_addr);
         end

         MODE_STACK:
         begin
            // stack is kept in high-speed RAM by software
            res_next.ea = stack_addr;
            res_next.area = AREA_HS_RAM;
         end

         MODE_JUMP_REG:
         begin
            res_next.ea = jump_addr;
            res_next.pc_load = I_VALID;
         end

         MODE_REL_BRANCH:
         begin
            res_next.ea = branch_addr;
            res_next.pc_load = I_VALID;
         end

         default:
         begin
            res_next.valid = 1'b0;
         end
      endcase
   end

   // result register; the output comes straight from it
   always_ff @(posedge I_REF_CLK)
   begin
      if (I_RST)
      begin
         res_reg <= '0;
      end
      else
      begin
         res_reg <= res_next;
      end
   end

   assign O_RES = res_reg;
endmodule : operand_address_generator
`default_nettype wire

// ===== dv/cpu_side_model.sv
`default_nettype none
module cpu_side_model import opaddr_pkg::*; (
   input wire logic i_clk,
   input wire regs_t i_regs,
   output var regs_t o_regs
);
   timeunit 1ns;
   timeprecision 100ps;
   always_ff @(posedge i_clk)
   begin
      o_regs <= i_regs;
      o_regs.stack_ptr <= {8'hFE, i_regs.stack_ptr[7:0] | 8'h20};
   end
endmodule : cpu_side_model
`default_nettype wire

// ===== dv/opaddr_sva.sv
`default_nettype none
module opaddr_sva import opaddr_pkg::*; (
   input wire logic I_REF_CLK,
   input wire logic I_RST,
   input wire logic I_VALID,
   input wire decode_t I_DEC,
   input wire regs_t I_REGS,
   input wire result_t O_RES
);
   timeunit 1ns;
   timeprecision 100ps;
   default clocking ck @(posedge I_REF_CLK);
   endclocking
   default disable iff (I_RST);
   a_direct_ea: assert property (I_VALID && I_DEC.mode == MODE_DIRECT |=>
      O_RES.ea == $past(I_DEC.absolute_address_operand)) else $error("direct ea");
   a_short_ea: assert property (I_VALID && I_DEC.mode == MODE_SHORT |=>
      O_RES.ea == {7'h7F, $past(I_DEC.field8) < 8'h20, $past(I_DEC.field8)}) else $error("short ea");
   a_short_area: assert property (I_VALID && I_DEC.mode == MODE_SHORT |=>
      O_RES.area == ($past(I_DEC.field8) < 8'h20 ? AREA_SFR : AREA_HS_RAM)) else $error("short area");
   a_sfr_ea: assert property (I_VALID && I_DEC.mode == MODE_SFR |=> O_RES.area == AREA_SFR &&
      O_RES.ea == {8'hFF, $past(I_DEC.field8)} && O_RES.sfr_hole == ($past(I_DEC.field8[7:4]) == 4'hD))
      else $error("sfr ea");
   a_based_ea: assert property (I_VALID && I_DEC.mode == MODE_BASED |=>
      O_RES.ea == 16'($past(I_REGS.base_pair) + $past(I_DEC.field8))) else $error("based ea");
   a_indirect_ea: assert property (I_VALID && I_DEC.mode == MODE_INDIRECT |=> O_RES.ea ==
      ($past(I_DEC.indirect_sel_base) ? $past(I_REGS.base_pair) : $past(I_REGS.pointer_pair))) else $error("ind ea");
   a_jump_pc: assert property (I_VALID && I_DEC.mode == MODE_JUMP_REG |=>
      O_RES.pc_load && O_RES.ea == $past(I_REGS.accumulator_pair)) else $error("jump");
   a_rel_branch: assert property (I_VALID && I_DEC.mode == MODE_REL_BRANCH |=> O_RES.pc_load &&
      O_RES.ea == 16'($past(I_DEC.next_pc) + {{8{$past(I_DEC.branch_displacement[7])}},
      $past(I_DEC.branch_displacement)})) else $error("rel branch");
   a_bit_mask: assert property (I_VALID && I_DEC.mode != MODE_NONE |=>
      O_RES.bit_mask == 8'h01 << $past(I_DEC.bit_pos)) else $error("bit mask");
   a_reg_sel: assert property (I_VALID && I_DEC.mode == MODE_REG |=> O_RES.area == AREA_REGFILE &&
      O_RES.reg_sel == $past(I_DEC.reg_code)) else $error("reg sel");
   a_pair_sel: assert property (I_VALID && I_DEC.mode == MODE_REG_PAIR |=> O_RES.area == AREA_REGFILE &&
      O_RES.pair_sel == $past(I_DEC.pair_operand)) else $error("pair sel");
   a_stack_ea: assert property (I_VALID && I_DEC.mode == MODE_STACK |=> O_RES.area == AREA_HS_RAM &&
      O_RES.ea == $past(I_REGS.stack_ptr)) else $error("stack ea");
   a_none_idle: assert property (I_DEC.mode == MODE_NONE |=> !O_RES.valid && !O_RES.pc_load) else $error("none mode");
   c_short_sfr: cover property (I_VALID && I_DEC.mode == MODE_SHORT && I_DEC.field8 < 8'h20);
   c_based_wrap: cover property (I_VALID && I_DEC.mode == MODE_BASED && I_REGS.base_pair[15:8] == 8'hFF);
   c_jump: cover property (I_VALID && I_DEC.mode == MODE_JUMP_REG);
   c_sfr_gap: cover property (I_VALID && I_DEC.mode == MODE_SFR && I_DEC.field8[7:4] == 4'hD);
endmodule : opaddr_sva
bind operand_address_generator opaddr_sva chk (.I_REF_CLK(I_REF_CLK), .I_RST(I_RST), .I_VALID(I_VALID),
   .I_DEC(I_DEC), .I_REGS(I_REGS), .O_RES(O_RES));
`default_nettype wire

// ===== dv/testbench.sv
`default_nettype none
module testbench import opaddr_pkg::*;;
   timeunit 1ns;
   timeprecision 100ps;
   logic I_REF_CLK = 1'b0, I_RST = 1'b1, I_VALID = 1'b0, armed = 1'b0, want_v = 1'b0;
   decode_t dec = '0;
   regs_t regs_in = '0;
   regs_t regs;
   result_t res;
   logic [16:0] want = '0;
   logic rst_seen = 1'b0;
   logic [7:0] corner [4] = '{8'h00, 8'h1F, 8'h20, 8'hFF};
   int num_errors = 0;
   int comparisons = 0;
   cpu_side_model far (.i_clk(I_REF_CLK), .i_regs(regs_in), .o_regs(regs));
   operand_address_generator uut (.I_REF_CLK(I_REF_CLK), .I_RST(I_RST), .I_VALID(I_VALID), .I_DEC(dec),
      .I_REGS(regs), .O_RES(res));
   function automatic logic [16:0] ea_of(decode_t d, regs_t r);
      case (d.mode)
         MODE_DIRECT: return {1'b1, d.absolute_address_operand};
         MODE_SHORT: return {1'b1, 7'h7F, d.field8 < 8'h20, d.field8};
         MODE_SFR: return {1'b1, 8'hFF, d.field8};
         MODE_INDIRECT: return {1'b1, d.indirect_sel_base ? r.base_pair : r.pointer_pair};
         MODE_BASED: return {1'b1, 16'(r.base_pair + d.field8)};
         MODE_STACK: return {1'b1, r.stack_ptr};
         MODE_JUMP_REG: return {1'b1, r.accumulator_pair};
         MODE_REL_BRANCH:
            return {1'b1, 16'(d.next_pc + {{8{d.branch_displacement[7]}}, d.branch_displacement})};
         default: return '0;
      endcase
   endfunction : ea_of
   task automatic give_verdict;
      if (num_errors == 0 && comparisons > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask : give_verdict
   initial
      forever #12.5 I_REF_CLK = ~I_REF_CLK;
   always @(posedge I_REF_CLK)
   begin
      if (armed)
      begin
         comparisons = comparisons + 1;
         if (res.valid !== want_v || (want[16] && res.ea !== want[15:0]))
         begin
            num_errors = num_errors + 1;
            $display("MISMATCH %0t ea %h valid %b", $time, res.ea, res.valid);
         end
      end
      if (rst_seen)
      begin
         comparisons = comparisons + 1;
         if (res !== '0)
         begin
            num_errors = num_errors + 1;
            $display("MISMATCH %0t result not cleared by reset", $time);
         end
      end
      rst_seen <= I_RST;
      armed <= !I_RST;
      want <= I_VALID ? ea_of(dec, regs) : '0;
      want_v <= I_VALID && dec.mode != MODE_NONE;
   end
   initial
   begin
      decode_t d;
      regs_t r;
      void'($urandom(41052));
      repeat (2) @(posedge I_REF_CLK);
      I_RST <= 1'b0;
      for (int i = 0; i < 600; i++)
      begin
         @(posedge I_REF_CLK);
         I_RST <= (i == 300);
         d = 61'({$urandom, $urandom});
         d.mode = mode_t'(4'($urandom % 11));
         if (d.mode == MODE_SHORT && d.reg_code[0])
            d.field8[0] = 1'b0;
         if ($urandom % 8 == 0)
            d.absolute_address_operand = 16'h0040 + 16'(2 * ($urandom % 32));
         if ($urandom % 2)
            d.field8 = corner[$urandom % 4];
         r = 80'({$urandom, $urandom, $urandom});
         if ($urandom % 2)
            r.base_pair[15:8] = 8'hFF;
         I_VALID <= ($urandom % 4) != 0;
         dec <= d;
         regs_in <= r;
      end
      repeat (3) @(posedge I_REF_CLK);
      give_verdict();
   end
endmodule : testbench
`default_nettype wire
